// *** hdl/rsq_cfg.svh ***
`ifndef RSQ_CFG_SVH
`define RSQ_CFG_SVH

// register addresses on the device register port
`define RSQ_ADDR_GAP_LO 8'h20
`define RSQ_ADDR_GAP_HI 8'h21
`define RSQ_ADDR_PICK 8'h22

// reset values
`define RSQ_RST_GAP_LO 8'h00
`define RSQ_RST_PICK 8'h98
`define RSQ_RST_BIT 1'h0
`define RSQ_HI_RSVD 6'h00
`define RSQ_READ_ZERO 8'h00

// field positions in the second delay register
`define RSQ_STRETCH_BIT 7
`define RSQ_GAP9_BIT 0

// strobe numbering
`define RSQ_NUM_STROBES 10
`define RSQ_STEP_FIRST 4'h1
`define RSQ_STEP_SEALED 4'h3
`define RSQ_STEP_LAST 4'hA
`define RSQ_STEP_ONE 4'h1
`define RSQ_STEP_TWO 4'h2
`define RSQ_CTRL_LO 4'h3
`define RSQ_CTRL_HI 4'hA

// timing, times in ms, clock in kHz
`define RSQ_CLK_KHZ 25000
`define RSQ_GAP_SHORT_MS 2
`define RSQ_GAP_LONG_MS 5
`define RSQ_DOWN_STRETCH 10

`endif

// *** hdl/rsq_pkg.sv ***
package rsq_pkg;

  // sequencer walk state
  typedef enum logic [1:0] {
    RSQ_IDLE,
    RSQ_UP,
    RSQ_DOWN
  } rsq_state_t;

endpackage : rsq_pkg

// *** hdl/rsq_gap_timer.sv ***
`timescale 1ns/100ps
`include "rsq_cfg.svh"

module rsq_gap_timer import rsq_pkg::*; #(
  parameter int unsigned CW = 21
) (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic load_i,
  input wire logic [CW-1:0] load_val_i,
  output logic expire_o
);

  localparam logic [CW-1:0] ONE_C = CW'(1);

  logic [CW-1:0] cnt_r; // cycles left in the running gap

  // load wins over counting; zero means idle
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_r <= '0;
    end else if (load_i) begin
      cnt_r <= load_val_i;
    end else if (cnt_r != '0) begin
      cnt_r <= cnt_r - ONE_C;
    end
  end

  // last cycle of a gap of N cycles, so the next event lands N edges after the load
  assign expire_o = (cnt_r == ONE_C);

endmodule : rsq_gap_timer

// *** hdl/rsq_sequencer.sv ***
`timescale 1ns/100ps
`include "rsq_cfg.svh"

module rsq_sequencer import rsq_pkg::*; #(
  parameter int unsigned CW = 21,
  parameter int unsigned GAP_SHORT_CYC = `RSQ_GAP_SHORT_MS * `RSQ_CLK_KHZ,
  parameter int unsigned GAP_LONG_CYC = `RSQ_GAP_LONG_MS * `RSQ_CLK_KHZ,
  parameter int unsigned STRETCH = `RSQ_DOWN_STRETCH
) (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  input wire logic power_up_i,
  input wire logic power_down_i,
  input wire logic fresh_seal_flag_i,
  output logic [`RSQ_NUM_STROBES-1:0] strobe_o,
  output logic buck_rail_one_en_o,
  output logic buck_rail_two_en_o,
  output logic busy_o
);

  // gap lengths in cycles, stretched forms precomputed so no multiplier is built
  localparam logic [CW-1:0] SHORT_C = CW'(GAP_SHORT_CYC);
  localparam logic [CW-1:0] LONG_C = CW'(GAP_LONG_CYC);
  localparam logic [CW-1:0] SHORT_X_C = CW'(GAP_SHORT_CYC * STRETCH);
  localparam logic [CW-1:0] LONG_X_C = CW'(GAP_LONG_CYC * STRETCH);
  localparam logic [3:0] STEP_INC = 4'h1;
  localparam logic [3:0] STEP_DEC2 = 4'h2;
  localparam logic [`RSQ_NUM_STROBES-1:0] STROBE_ONE = `RSQ_NUM_STROBES'(1);

  // register storage
  logic [7:0] gap_lo_r; // gap selects one to eight
  logic gap9_r; // ninth gap select
  logic stretch_r; // power-down stretch
  logic [7:0] pick_r; // buck rail strobe picks
  logic [7:0] rdata_r; // read data holding

  // walk state
  rsq_state_t state_r;
  rsq_state_t state_nxt;
  logic [3:0] step_r; // last strobe fired
  logic [`RSQ_NUM_STROBES-1:0] strobe_r;
  logic [1:0] rail_en_r; // per-rail enable

  // register decode
  wire wr_lo = reg_wr_i && (reg_addr_i == `RSQ_ADDR_GAP_LO);
  wire wr_hi = reg_wr_i && (reg_addr_i == `RSQ_ADDR_GAP_HI);
  wire wr_pick = reg_wr_i && (reg_addr_i == `RSQ_ADDR_PICK);
  wire [7:0] hi_view = {stretch_r, `RSQ_HI_RSVD, gap9_r};
  wire [7:0] rd_mux = (reg_addr_i == `RSQ_ADDR_GAP_LO) ? gap_lo_r :
                      (reg_addr_i == `RSQ_ADDR_GAP_HI) ? hi_view :
                      (reg_addr_i == `RSQ_ADDR_PICK) ? pick_r : `RSQ_READ_ZERO;

  // register writes; reserved bits of the second register are never stored
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      gap_lo_r <= `RSQ_RST_GAP_LO;
      gap9_r <= `RSQ_RST_BIT;
      stretch_r <= `RSQ_RST_BIT;
      pick_r <= `RSQ_RST_PICK;
    end else begin
      if (wr_lo) gap_lo_r <= reg_wdata_i;
      if (wr_hi) gap9_r <= reg_wdata_i[`RSQ_GAP9_BIT];
      if (wr_hi) stretch_r <= reg_wdata_i[`RSQ_STRETCH_BIT];
      if (wr_pick) pick_r <= reg_wdata_i;
    end
  end

  // read data lands one cycle after the read strobe, unmapped reads zero
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) rdata_r <= `RSQ_READ_ZERO;
    else if (reg_rd_i) rdata_r <= rd_mux;
  end

  // walk decisions
  wire timer_expire;
  wire idle = (state_r == RSQ_IDLE);
  wire start_up = idle && power_up_i; // up wins a tie with down
  wire start_down = idle && !power_up_i && power_down_i;
  wire tick = !idle && timer_expire;
  wire going_up = start_up || (state_r == RSQ_UP);
  // sealed parts start the up walk and end the down walk at strobe three
  wire [3:0] low_step = fresh_seal_flag_i ? `RSQ_STEP_SEALED : `RSQ_STEP_FIRST;
  wire [3:0] up_inc = step_r + STEP_INC;
  wire [3:0] up_next = (up_inc < low_step) ? low_step : up_inc;
  wire [3:0] dn_next = step_r - STEP_INC;
  wire [3:0] fire_step = start_up ? low_step :
                         start_down ? `RSQ_STEP_LAST :
                         going_up ? up_next : dn_next;
  // a down step into a sealed strobe ends the walk with no pulse
  wire fire_ok = start_up || start_down || (tick && (going_up || dn_next >= low_step));
  wire walk_end = tick && (going_up ? (fire_step == `RSQ_STEP_LAST) :
                           (dn_next <= low_step));
  wire timer_load = fire_ok && !walk_end;

  // gap k lies between strobes k and k+1 and is held in bit k-1
  wire [8:0] gap_sel_vec = {gap9_r, gap_lo_r};
  wire [3:0] gap_idx = going_up ? (fire_step - STEP_INC) : (fire_step - STEP_DEC2);
  wire gap_sel = gap_sel_vec[gap_idx];
  wire stretch_now = stretch_r && !going_up;
  wire [CW-1:0] load_val = stretch_now ? (gap_sel ? LONG_X_C : SHORT_X_C) :
                           (gap_sel ? LONG_C : SHORT_C);
  wire [`RSQ_NUM_STROBES-1:0] strobe_nxt =
    fire_ok ? (STROBE_ONE << (fire_step - STEP_INC)) : '0;

  // next state
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      RSQ_IDLE: begin
        if (start_up) state_nxt = RSQ_UP;
        else if (start_down) state_nxt = RSQ_DOWN;
      end
      RSQ_UP, RSQ_DOWN: begin
        if (walk_end) state_nxt = RSQ_IDLE; // requests while walking are ignored
      end
      default: state_nxt = RSQ_IDLE;
    endcase
  end

  // walk registers
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      state_r <= RSQ_IDLE;
      step_r <= `RSQ_STEP_FIRST;
      strobe_r <= '0;
    end else begin
      state_r <= state_nxt;
      strobe_r <= strobe_nxt;
      if (fire_ok) step_r <= fire_step;
    end
  end

  rsq_gap_timer #(.CW(CW)) u_timer (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .load_i(timer_load),
    .load_val_i(load_val),
    .expire_o(timer_expire)
  );

  // per-rail enables for picks 3 to A: set on power-up at its strobe, cleared on power-down
  genvar gi;
  for (gi = 0; gi < 2; gi++) begin : g_rail
    wire [3:0] code = pick_r[gi*4 +: 4];
    wire in_ctrl = (code >= `RSQ_CTRL_LO) && (code <= `RSQ_CTRL_HI);
    wire hit = in_ctrl && fire_ok && (fire_step == code);
    always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) rail_en_r[gi] <= 1'b0;
      else if (hit) rail_en_r[gi] <= going_up;
    end
  end

  assign reg_rdata_o = rdata_r;
  assign strobe_o = strobe_r;
  assign buck_rail_one_en_o = rail_en_r[0];
  assign buck_rail_two_en_o = rail_en_r[1];
  assign busy_o = !idle;

  // ---------------- checks ----------------
  logic [CW:0] since_r; // cycles since the last strobe decision
  logic [CW-1:0] last_load_r; // gap length loaded at that decision
  logic [`RSQ_NUM_STROBES-1:0] last_strobe_r;
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      since_r <= '0;
      last_load_r <= '0;
      last_strobe_r <= '0;
    end else begin
      since_r <= fire_ok ? (CW+1)'(1) : since_r + (CW+1)'(1);
      if (timer_load) last_load_r <= load_val;
      if (strobe_nxt != '0) last_strobe_r <= strobe_nxt;
    end
  end

  property p_up_short;
    @(posedge clock_i) disable iff (rst_i)
    (timer_load && going_up && !gap_sel) |-> (load_val == SHORT_C);
  endproperty
  a_up_short: assert property (p_up_short) else $error("up gap not short");

  property p_ninth_gap;
    @(posedge clock_i) disable iff (rst_i)
    (timer_load && going_up && fire_step == 4'h9) |-> (load_val == (gap9_r ? LONG_C : SHORT_C));
  endproperty
  a_ninth_gap: assert property (p_ninth_gap) else $error("ninth gap wrong");

  property p_down_stretch;
    @(posedge clock_i) disable iff (rst_i)
    (timer_load && !going_up && stretch_r) |-> (load_val == (gap_sel ? LONG_X_C : SHORT_X_C));
  endproperty
  a_down_stretch: assert property (p_down_stretch) else $error("stretch missing");

  property p_up_unscaled;
    @(posedge clock_i) disable iff (rst_i)
    (timer_load && going_up) |-> (load_val == SHORT_C || load_val == LONG_C);
  endproperty
  a_up_unscaled: assert property (p_up_unscaled) else $error("up gap scaled");

  property p_rail_on;
    @(posedge clock_i) disable iff (rst_i)
    (going_up && fire_ok && fire_step == pick_r[3:0] && pick_r[3:0] >= `RSQ_CTRL_LO
     && pick_r[3:0] <= `RSQ_CTRL_HI) |=> buck_rail_one_en_o;
  endproperty
  a_rail_on: assert property (p_rail_on) else $error("rail one not enabled");

  property p_uncontrolled;
    @(posedge clock_i) disable iff (rst_i)
    (pick_r[7:4] < `RSQ_CTRL_LO || pick_r[7:4] > `RSQ_CTRL_HI) |=> $stable(buck_rail_two_en_o);
  endproperty
  a_uncontrolled: assert property (p_uncontrolled) else $error("free rail switched");

  property p_reserved;
    @(posedge clock_i) disable iff (rst_i)
    (reg_rd_i && reg_addr_i == `RSQ_ADDR_GAP_HI) |=> (reg_rdata_o[6:1] == `RSQ_HI_RSVD);
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bits nonzero");

  property p_seal;
    @(posedge clock_i) disable iff (rst_i)
    (strobe_o[1:0] != 2'h0) |-> !$past(fresh_seal_flag_i);
  endproperty
  a_seal: assert property (p_seal) else $error("sealed strobe fired");

  property p_gap_time;
    @(posedge clock_i) disable iff (rst_i)
    tick |-> (since_r == (CW+1)'(last_load_r));
  endproperty
  a_gap_time: assert property (p_gap_time) else $error("gap length wrong");

  property p_up_order;
    @(posedge clock_i) disable iff (rst_i)
    (tick && state_r == RSQ_UP && step_r >= `RSQ_STEP_SEALED) |=>
      (strobe_o == (last_strobe_r & ($past(last_strobe_r) << 1)));
  endproperty
  a_up_order: assert property (p_up_order) else $error("up walk out of order");

  c_up_walk: cover property (@(posedge clock_i) disable iff (rst_i) strobe_o[9] && going_up);
  c_down_end: cover property (@(posedge clock_i) disable iff (rst_i) walk_end && !going_up);
  c_stretch: cover property (@(posedge clock_i) disable iff (rst_i) timer_load && stretch_now);

endmodule : rsq_sequencer

// *** verif/rsq_host_model.sv ***
`timescale 1ns/100ps
// host side of the register port, one access at a time
module rsq_host_model (
  input wire logic clock_i,
  input wire logic [7:0] reg_rdata_i,
  output logic [7:0] reg_addr_o,
  output logic [7:0] reg_wdata_o,
  output logic reg_wr_o,
  output logic reg_rd_o
);
  // quiet bus at time zero
  initial begin
    reg_addr_o = 8'h00;
    reg_wdata_o = 8'h00;
    reg_wr_o = 1'b0;
    reg_rd_o = 1'b0;
  end

  // write strobe stands for one edge, then the data lines are scrambled
  task automatic wr_reg(input logic [7:0] addr, input logic [7:0] data);
    @(posedge clock_i);
    reg_addr_o <= addr;
    reg_wdata_o <= data;
    reg_wr_o <= 1'b1;
    @(posedge clock_i);
    reg_wr_o <= 1'b0;
    reg_wdata_o <= ~data; // stale data must never look valid
  endtask : wr_reg

  // read data is taken one edge after the strobe edge, where it is settled
  task automatic rd_reg(input logic [7:0] addr, output logic [7:0] data);
    @(posedge clock_i);
    reg_addr_o <= addr;
    reg_rd_o <= 1'b1;
    @(posedge clock_i);
    reg_rd_o <= 1'b0;
    @(posedge clock_i);
    #1;
    data = reg_rdata_i;
  endtask : rd_reg
endmodule : rsq_host_model

// *** verif/rail_sequencer_timing_tb.sv ***
`timescale 1ns/100ps
module rail_sequencer_timing_tb;
  localparam int SHORT = 4; // shortened gap counts keep the run brief
  localparam int LONG = 7;
  localparam int STR = 10;
  typedef struct packed {logic [7:0] a; logic [7:0] d; logic w; logic [7:0] e;} rsq_row_t;
  logic clock_i, rst_i, power_up_i, power_down_i, seal, wr, rd, rail1, rail2, busy;
  logic [7:0] addr, wdata, rdata, rd_val;
  logic [7:0] gap_lo, gap_hi, pick; // mirror of what the registers hold
  logic [9:0] strobe;
  int n_mismatch, total_checks;
  // address, write data, write first, expected read back
  rsq_row_t rows [8] = '{'{8'h20, 8'h00, 1'b0, 8'h00}, '{8'h21, 8'h00, 1'b0, 8'h00},
    '{8'h22, 8'h00, 1'b0, 8'h98}, '{8'h23, 8'h00, 1'b0, 8'h00},
    '{8'h21, 8'hFF, 1'b1, 8'h81}, '{8'h20, 8'hA5, 1'b1, 8'hA5},
    '{8'h30, 8'hFF, 1'b1, 8'h00}, '{8'h22, 8'h00, 1'b0, 8'h98}};

  always #20 clock_i = ~clock_i;

  rsq_sequencer #(.CW(21), .GAP_SHORT_CYC(SHORT), .GAP_LONG_CYC(LONG), .STRETCH(STR)) i_dut (
    .clock_i(clock_i), .rst_i(rst_i), .reg_addr_i(addr), .reg_wdata_i(wdata),
    .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .power_up_i(power_up_i),
    .power_down_i(power_down_i), .fresh_seal_flag_i(seal), .strobe_o(strobe),
    .buck_rail_one_en_o(rail1), .buck_rail_two_en_o(rail2), .busy_o(busy));

  rsq_host_model i_host (.clock_i(clock_i), .reg_rdata_i(rdata), .reg_addr_o(addr),
    .reg_wdata_o(wdata), .reg_wr_o(wr), .reg_rd_o(rd));

  // single comparison point, four-state exact
  task automatic check(input logic [9:0] seen, input logic [9:0] expd);
    total_checks++;
    if (seen !== expd) begin
      n_mismatch++;
      $display("Error at %0t: seen %h expected %h", $time, seen, expd);
    end
  endtask : check

  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : report_and_stop

  // one walk; the raised requests stay high until the last gap, so while busy they must be ignored
  task automatic walk(input logic up, input int first);
    int k, n, g, mult;
    logic s;
    k = up ? first : 10;
    mult = (!up && gap_hi[7]) ? STR : 1;
    @(posedge clock_i);
    power_up_i <= up;
    power_down_i <= 1'b1; // up wins when both are raised in idle
    for (int i = 0; i < 11 - first; i++) begin
      n = 0;
      do begin
        @(posedge clock_i);
        // drop the requests during the last gap, or idle would start a new walk at once
        if (i == 10 - first) begin
          power_up_i <= 1'b0;
          power_down_i <= 1'b0;
        end
        #1;
        n++;
      end while (strobe === 10'h000 && n < 300);
      if (n >= 300) begin
        n_mismatch++;
        report_and_stop();
      end
      g = up ? k - 1 : k; // gap just waited out
      s = (g == 9) ? gap_hi[0] : gap_lo[(g > 0) ? g - 1 : 0];
      if (i > 0) check(10'(n), 10'(s ? LONG * mult : SHORT * mult));
      check(strobe, 10'h001 << (k - 1));
      // only codes 3 to A move a rail; lower codes leave it alone
      if (k >= 3 && k == int'(pick[3:0])) check({9'h000, rail1}, {9'h000, up});
      if (k >= 3 && k == int'(pick[7:4])) check({9'h000, rail2}, {9'h000, up});
      k = up ? k + 1 : k - 1;
    end
    @(posedge clock_i);
    power_up_i <= 1'b0;
    power_down_i <= 1'b0;
    #1;
    check({9'h000, busy}, 10'h000);
  endtask : walk

  // main sequence
  initial begin
    clock_i = 1'b0;
    rst_i = 1'b1;
    power_up_i = 1'b0;
    power_down_i = 1'b0;
    seal = 1'b1;
    n_mismatch = 0;
    total_checks = 0;
    repeat (8) @(posedge clock_i);
    #1;
    check({strobe[6:0], rail1, rail2, busy}, 10'h000);
    check(strobe, 10'h000);
    check({2'b00, rdata}, 10'h000);
    @(posedge clock_i);
    rst_i <= 1'b0;
    foreach (rows[i]) begin
      if (rows[i].w) i_host.wr_reg(rows[i].a, rows[i].d);
      i_host.rd_reg(rows[i].a, rd_val);
      check({2'b00, rd_val}, {2'b00, rows[i].e});
    end
    $display("test registers done");
    gap_lo = 8'hA5;
    gap_hi = 8'h81;
    pick = 8'h98;
    walk(1'b1, 3); // sealed up walk, stretch set but unused
    $display("test sealed power-up done");
    i_host.wr_reg(8'h22, 8'h25);
    pick = 8'h25;
    @(posedge clock_i);
    seal <= 1'b0;
    walk(1'b0, 1); // stretched down walk, rail two outside control
    check({8'h00, rail1, rail2}, 10'h001);
    $display("test stretched power-down done");
    i_host.wr_reg(8'h21, 8'h01);
    i_host.wr_reg(8'h22, 8'h2A);
    gap_hi = 8'h01;
    pick = 8'h2A;
    walk(1'b1, 1); // fresh up walk from strobe one, long ninth gap
    check({8'h00, rail1, rail2}, 10'h003);
    @(posedge clock_i);
    seal <= 1'b1;
    walk(1'b0, 3); // sealed down walk stops at strobe three
    $display("test fresh power-up and sealed power-down done");
    // reset in mid-walk: walk stops, rails drop, registers return to reset values
    i_host.wr_reg(8'h20, 8'h3C);
    gap_lo = 8'h3C;
    @(posedge clock_i);
    power_up_i <= 1'b1;
    repeat (6) @(posedge clock_i);
    rst_i <= 1'b1;
    power_up_i <= 1'b0;
    repeat (2) @(posedge clock_i);
    #1;
    check({strobe[6:0], rail1, rail2, busy}, 10'h000);
    check(strobe, 10'h000);
    @(posedge clock_i);
    rst_i <= 1'b0;
    i_host.rd_reg(8'h20, rd_val);
    check({2'b00, rd_val}, 10'h000);
    i_host.rd_reg(8'h22, rd_val);
    check({2'b00, rd_val}, 10'h098);
    $display("test mid-run reset done");
    report_and_stop();
  end
endmodule : rail_sequencer_timing_tb
